// *** hw/reset_and_stop_recovery_ctrl.sv ***
`default_nettype none
module reset_and_stop_recovery_ctrl #(
	parameter logic [12:0] P_HOLD_LONG = rst_stop_pkg::HOLD_LONG_CYCLES
) (
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	input wire logic I_RESET_PIN_N,
	output logic O_RESET_PIN_N,
	output logic O_RESET_PIN_OE,
	input wire logic I_GPIO_RESET_DRIVE,
	input wire logic I_OSC_TICK,
	input wire logic I_XTAL_EN,
	input wire logic I_STOP_MODE,
	input wire logic I_WDT_TIMEOUT,
	input wire logic I_WDT_RESET_MODE,
	input wire logic I_IRQ_ENABLE,
	input wire logic [7:0] I_GPIO_PINS,
	input wire logic [7:0] I_GPIO_WAKE_EN,
	input wire logic I_DBG_RESET_REQ,
	input wire logic I_DBG_PIN,
	input wire logic I_DBG_BIT_TICK,
	input wire logic I_DBG_STOP_SAMPLE,
	input wire logic I_DBG_TX_COLLISION,
	input wire logic I_CAUSE_READ,
	input wire logic [7:0] I_PMEM_DATA,
	output logic O_SYS_RESET,
	output logic O_CPU_RESET,
	output logic O_DBG_REQ_CLEAR,
	output logic O_DBG_ERROR,
	output logic O_OSC_IPO_SELECT,
	output logic O_WDT_IRQ,
	output logic O_PORT_IN_HOLD,
	output logic O_PORT_IN_LOAD,
	output logic [7:0] O_PORT_IN_DATA,
	output logic O_PMEM_RD,
	output logic [15:0] O_PMEM_ADDR,
	output logic O_PC_LOAD,
	output logic [15:0] O_PC,
	output logic [7:0] O_RESET_CAUSE
);

	// pick the hold limit for the current oscillator option
	function automatic logic [12:0] hold_limit(input logic xtal);
		hold_limit = xtal ? P_HOLD_LONG : rst_stop_pkg::HOLD_SHORT_CYCLES;
	endfunction

	// saturating increment for the debug break counter
	function automatic logic [3:0] sat_inc(input logic [3:0] v);
		sat_inc = (v == 4'hF) ? v : v + 4'h1;
	endfunction

	// synchroniser stages; first stages feed only the second
	logic rst_meta;
	logic rst_sync;
	logic [7:0] gpio_meta;
	logic [7:0] gpio_sync;
	logic dbg_meta;
	logic dbg_sync;

	rst_stop_pkg::seq_state_t state;
	rst_stop_pkg::seq_state_t next_state;

	logic [2:0] low_cnt; // consecutive low samples of the pin
	logic [12:0] hold_cnt; // oscillator ticks spent in hold or wake
	logic [3:0] break_cnt; // consecutive low bit times on debug line
	logic [7:0] gpio_snap; // pin levels captured at stop entry
	logic [7:0] pend_cause; // cause pattern loaded when the hold or wake delay ends
	logic wdt_irq_pend; // watchdog interrupt owed after wake
	logic drive_pin; // we pull the reset pin low
	logic [7:0] vec_hi; // high byte of the reset vector
	logic fetch_tail; // first cycle after the vector fetch

	// two-flop synchronisers for every pin input
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rst_meta <= 1'b1;
			rst_sync <= 1'b1;
			gpio_meta <= 8'h00;
			gpio_sync <= 8'h00;
			dbg_meta <= 1'b1;
			dbg_sync <= 1'b1;
		end else begin
			rst_meta <= I_RESET_PIN_N;
			rst_sync <= rst_meta;
			gpio_meta <= I_GPIO_PINS;
			gpio_sync <= gpio_meta;
			dbg_meta <= I_DBG_PIN;
			dbg_sync <= dbg_meta;
		end
	end

	// state decode
	wire in_run = (state == rst_stop_pkg::ST_RUN);
	wire in_stop = (state == rst_stop_pkg::ST_STOP);
	wire in_hold = (state == rst_stop_pkg::ST_HOLD);
	wire in_wake = (state == rst_stop_pkg::ST_WAKE);

	// pin qualifier: four low samples when running, the glitch minimum in stop;
	// our own drive is masked so the indicator cannot retrigger us
	wire pin_low = !rst_sync && !drive_pin && !I_GPIO_RESET_DRIVE;
	wire [2:0] low_need = in_stop ? 3'(rst_stop_pkg::GLITCH_CYCLES) : 3'(rst_stop_pkg::PIN_LOW_MIN_CYCLES);
	wire pin_reset = pin_low && ((low_cnt + 3'h1) >= low_need);

	// hold/wake time-out, counted only on oscillator ticks
	wire hold_done = I_OSC_TICK && (hold_cnt >= hold_limit(I_XTAL_EN) - 13'h1);

	// debug line error detection
	wire break_seen = I_DBG_BIT_TICK && !dbg_sync && (sat_inc(break_cnt) >= rst_stop_pkg::BREAK_BITS);
	wire frame_err = I_DBG_STOP_SAMPLE && !dbg_sync;
	wire dbg_err = break_seen || frame_err || I_DBG_TX_COLLISION;

	// wake sources while stopped, and reset requests while running
	wire gpio_change = |((gpio_sync ^ gpio_snap) & I_GPIO_WAKE_EN);
	wire wdt_reset_run = in_run && I_WDT_TIMEOUT && I_WDT_RESET_MODE;
	wire dbg_reset_run = in_run && I_DBG_RESET_REQ;

	// entry into a full system reset or a wake and the cause it will leave behind
	wire enter_hold = (in_run && (pin_reset || wdt_reset_run || dbg_reset_run))
		|| (in_stop && (pin_reset || dbg_err));
	wire enter_wake = in_stop && !pin_reset && !dbg_err && (I_WDT_TIMEOUT || gpio_change);
	wire [7:0] entry_cause = pin_reset ? rst_stop_pkg::CAUSE_EXT
		: (dbg_err || dbg_reset_run) ? rst_stop_pkg::CAUSE_DEBUG
		: wdt_reset_run ? rst_stop_pkg::CAUSE_WDT
		: (I_WDT_TIMEOUT ? rst_stop_pkg::CAUSE_STOP_WDT : rst_stop_pkg::CAUSE_STOP_GPIO);
	wire leave_reset = (state == rst_stop_pkg::ST_FETCH_LO);
	wire cause_load = ((in_hold || in_wake) && hold_done && (next_state != rst_stop_pkg::ST_HOLD));

	// next-state decode
	always_comb begin
		next_state = state;
		unique case (state)
			rst_stop_pkg::ST_RUN: begin
				if (enter_hold) begin
					next_state = rst_stop_pkg::ST_HOLD;
				end else if (I_STOP_MODE) begin
					next_state = rst_stop_pkg::ST_STOP;
				end
			end
			rst_stop_pkg::ST_STOP: begin
				if (enter_hold) begin
					next_state = rst_stop_pkg::ST_HOLD;
				end else if (enter_wake) begin
					next_state = rst_stop_pkg::ST_WAKE;
				end
			end
			rst_stop_pkg::ST_HOLD: begin
				// a pin held low past the time-out keeps us in reset
				if (hold_done) begin
					next_state = rst_sync ? rst_stop_pkg::ST_FETCH_HI : rst_stop_pkg::ST_EXTEND;
				end
			end
			rst_stop_pkg::ST_WAKE: begin
				if (hold_done) begin
					next_state = rst_stop_pkg::ST_FETCH_HI;
				end
			end
			rst_stop_pkg::ST_EXTEND: begin
				// first rising clock edge with the pin seen high
				if (rst_sync) begin
					next_state = rst_stop_pkg::ST_FETCH_HI;
				end
			end
			rst_stop_pkg::ST_FETCH_HI: begin
				next_state = rst_stop_pkg::ST_FETCH_LO;
			end
			rst_stop_pkg::ST_FETCH_LO: begin
				next_state = rst_stop_pkg::ST_RUN;
			end
			default: begin
				// an illegal code falls back into a full reset
				next_state = rst_stop_pkg::ST_HOLD;
			end
		endcase
	end

	// state register; power-on starts in hold
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			state <= rst_stop_pkg::ST_HOLD;
		end else begin
			state <= next_state;
		end
	end

	// low-pulse counter, cleared by any high sample
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			low_cnt <= 3'h0;
		end else if (pin_low && (in_run || in_stop)) begin
			low_cnt <= (low_cnt == 3'h7) ? low_cnt : low_cnt + 3'h1;
		end else begin
			low_cnt <= 3'h0;
		end
	end

	// hold counter restarts on every entry into hold or wake
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			hold_cnt <= 13'h0000;
		end else if (!(in_hold || in_wake) || hold_done) begin
			hold_cnt <= 13'h0000;
		end else if (I_OSC_TICK) begin
			hold_cnt <= hold_cnt + 13'h0001;
		end
	end

	// break counter counts low bit times on the debug line
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			break_cnt <= 4'h0;
		end else if (I_DBG_BIT_TICK) begin
			break_cnt <= dbg_sync ? 4'h0 : sat_inc(break_cnt);
		end
	end

	// pin levels captured at stop entry for change detection
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			gpio_snap <= 8'h00;
		end else if (!in_stop) begin
			gpio_snap <= gpio_sync;
		end
	end

	// pending cause and the owed watchdog interrupt
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			pend_cause <= rst_stop_pkg::CAUSE_RESET_VALUE;
			wdt_irq_pend <= 1'b0;
		end else if (enter_hold || enter_wake) begin
			pend_cause <= entry_cause;
			wdt_irq_pend <= enter_wake && I_WDT_TIMEOUT && !I_WDT_RESET_MODE && I_IRQ_ENABLE;
		end else if (leave_reset) begin
			wdt_irq_pend <= 1'b0;
		end
	end

	// cause register: loaded as the hold or wake delay ends; a read clears the flags,
	// but a load in the same cycle wins so no event is lost
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_RESET_CAUSE <= rst_stop_pkg::CAUSE_RESET_VALUE;
		end else if (cause_load) begin
			O_RESET_CAUSE <= pend_cause;
		end else if (I_CAUSE_READ) begin
			O_RESET_CAUSE <= O_RESET_CAUSE & ~rst_stop_pkg::CAUSE_FLAG_MASK;
		end
	end

	// open-drain reset indicator; pin stays driven for the whole delay.
	// the synchroniser still shows our own low for two cycles after release,
	// so a hold normally passes briefly through extend before the fetch
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			drive_pin <= 1'b1;
		end else begin
			drive_pin <= (next_state == rst_stop_pkg::ST_HOLD);
		end
	end

	assign O_RESET_PIN_N = 1'b0;
	assign O_RESET_PIN_OE = drive_pin || I_GPIO_RESET_DRIVE;

	// reset levels: system reset only in hold and extend, CPU also during wake and fetch;
	// wake leaves the rest of the chip's registers alone
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_SYS_RESET <= 1'b1;
			O_CPU_RESET <= 1'b1;
		end else begin
			O_SYS_RESET <= (next_state == rst_stop_pkg::ST_HOLD)
				|| (next_state == rst_stop_pkg::ST_EXTEND);
			O_CPU_RESET <= (next_state != rst_stop_pkg::ST_RUN)
				&& (next_state != rst_stop_pkg::ST_STOP);
		end
	end

	// one-cycle event outputs
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_DBG_REQ_CLEAR <= 1'b0;
			O_DBG_ERROR <= 1'b0;
			O_OSC_IPO_SELECT <= 1'b0;
			O_WDT_IRQ <= 1'b0;
		end else begin
			O_DBG_REQ_CLEAR <= dbg_reset_run && enter_hold && !pin_reset;
			O_DBG_ERROR <= dbg_err;
			O_OSC_IPO_SELECT <= enter_wake;
			O_WDT_IRQ <= leave_reset && wdt_irq_pend;
		end
	end

	// port input data is frozen in stop and wake; only the level still
	// present when the wake delay ends is handed to the port register
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_PORT_IN_HOLD <= 1'b0;
			O_PORT_IN_LOAD <= 1'b0;
			O_PORT_IN_DATA <= 8'h00;
		end else begin
			O_PORT_IN_HOLD <= (next_state == rst_stop_pkg::ST_STOP)
				|| (next_state == rst_stop_pkg::ST_WAKE);
			O_PORT_IN_LOAD <= in_wake && hold_done;
			if (in_wake && hold_done) begin
				O_PORT_IN_DATA <= gpio_sync;
			end
		end
	end

	// vector fetch: high byte address, then low byte, then load PC;
	// memory data is taken one cycle after each read strobe
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_PMEM_RD <= 1'b0;
			O_PMEM_ADDR <= 16'h0000;
			vec_hi <= 8'h00;
			fetch_tail <= 1'b0;
			O_PC_LOAD <= 1'b0;
			O_PC <= 16'h0000;
		end else begin
			O_PMEM_RD <= (next_state == rst_stop_pkg::ST_FETCH_HI)
				|| (next_state == rst_stop_pkg::ST_FETCH_LO);
			if (next_state == rst_stop_pkg::ST_FETCH_HI) begin
				O_PMEM_ADDR <= rst_stop_pkg::VECTOR_HI_ADDR;
			end else if (next_state == rst_stop_pkg::ST_FETCH_LO) begin
				O_PMEM_ADDR <= rst_stop_pkg::VECTOR_LO_ADDR;
			end
			if (state == rst_stop_pkg::ST_FETCH_LO) begin
				vec_hi <= I_PMEM_DATA;
			end
			// read strobe is already low here, so the tail flag marks the low byte
			fetch_tail <= leave_reset;
			O_PC_LOAD <= fetch_tail;
			if (fetch_tail) begin
				O_PC <= {vec_hi, I_PMEM_DATA};
			end
		end
	end

endmodule
`default_nettype wire

// *** hw/rst_stop_pkg.sv ***
`default_nettype none
package rst_stop_pkg;
	// sequencer states, one-hot
	typedef enum logic [6:0] {
		ST_RUN = 7'h01,
		ST_STOP = 7'h02,
		ST_HOLD = 7'h04,
		ST_WAKE = 7'h08,
		ST_EXTEND = 7'h10,
		ST_FETCH_HI = 7'h20,
		ST_FETCH_LO = 7'h40
	} seq_state_t;

	// timing of the reset pin qualifier
	localparam int SYS_CLK_PERIOD_NS = 10;
	localparam int PIN_LOW_MIN_CYCLES = 4;
	localparam int GLITCH_MIN_NS = 12;
	localparam int GLITCH_RAW_CYCLES = (GLITCH_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int GLITCH_CYCLES = (GLITCH_RAW_CYCLES < 1) ? 1 : GLITCH_RAW_CYCLES;
	localparam int LOW_CNT_W = 3;

	// hold period in internal oscillator cycles
	localparam int HOLD_CNT_W = 13;
	localparam logic [12:0] HOLD_SHORT_CYCLES = 13'd66;
	localparam logic [12:0] HOLD_LONG_CYCLES = 13'd5000;

	// reset vector location
	localparam int ADDR_W = 16;
	localparam logic [15:0] VECTOR_HI_ADDR = 16'h0002;
	localparam logic [15:0] VECTOR_LO_ADDR = 16'h0003;

	// debug line break length in bit times
	localparam int BREAK_CNT_W = 4;
	localparam logic [3:0] BREAK_BITS = 4'h9;

	// reset cause register layout
	localparam int CAUSE_POR_BIT = 7;
	localparam int CAUSE_STOP_BIT = 6;
	localparam int CAUSE_WDT_BIT = 5;
	localparam int CAUSE_EXT_BIT = 4;
	localparam logic [7:0] CAUSE_RESET_VALUE = 8'h80;
	localparam logic [7:0] CAUSE_FLAG_MASK = 8'hF0;
	localparam logic [7:0] CAUSE_EXT = 8'h10;
	localparam logic [7:0] CAUSE_WDT = 8'h20;
	localparam logic [7:0] CAUSE_DEBUG = 8'h80;
	localparam logic [7:0] CAUSE_STOP_GPIO = 8'h40;
	localparam logic [7:0] CAUSE_STOP_WDT = 8'h60;

	localparam int GPIO_W = 8;
endpackage
`default_nettype wire

// *** sim/board_model.sv ***
`default_nettype none
// reset source, pull-up and vector memory on the board
module board_model (
	input wire logic i_clk, // memory clock
	input wire logic i_pull_low, // source asserts the pin
	input wire logic i_oe, // device sinks the pin
	input wire logic [15:0] i_addr, // fetch address
	output logic o_pin_n, // resolved pin level
	output var logic [7:0] o_data // program memory byte, one cycle after address
);
	timeunit 1ns;
	timeprecision 1ns;
	// pull-up wins unless a party sinks current
	assign o_pin_n = !(i_pull_low || i_oe);
	// vector bytes; elsewhere a distinct pattern
	always_ff @(posedge i_clk) begin
		o_data <= (i_addr == 16'h0002) ? 8'hA5 : (i_addr == 16'h0003) ? 8'h3C : 8'h5A;
	end
endmodule
`default_nettype wire

// *** sim/rst_stop_monitor.sv ***
`default_nettype none
module rst_stop_monitor #(
	parameter logic [12:0] P_HOLD_LONG = 13'h1388
) (
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	input wire logic I_RESET_PIN_N,
	input wire logic O_RESET_PIN_N,
	input wire logic O_RESET_PIN_OE,
	input wire logic I_GPIO_RESET_DRIVE,
	input wire logic I_WDT_RESET_MODE,
	input wire logic I_IRQ_ENABLE,
	input wire logic I_CAUSE_READ,
	input wire logic O_SYS_RESET,
	input wire logic O_CPU_RESET,
	input wire logic O_DBG_REQ_CLEAR,
	input wire logic O_OSC_IPO_SELECT,
	input wire logic O_WDT_IRQ,
	input wire logic O_PORT_IN_HOLD,
	input wire logic O_PMEM_RD,
	input wire logic [15:0] O_PMEM_ADDR,
	input wire logic O_PC_LOAD,
	input wire logic [7:0] O_RESET_CAUSE
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_ARST_N);
	// open drain: only ever a low drive
	property p_pin_val; O_RESET_PIN_N == 1'b0; endproperty
	a_pin_val: assert property (p_pin_val) else $error("pin output high");
	property p_gpio; I_GPIO_RESET_DRIVE |-> O_RESET_PIN_OE; endproperty
	a_gpio: assert property (p_gpio) else $error("gpio drive ignored");
	property p_sys_cpu; O_SYS_RESET |-> O_CPU_RESET; endproperty
	a_sys_cpu: assert property (p_sys_cpu) else $error("cpu free in reset");
	// pin held low by the source keeps reset after the drive ends
	property p_extend;
		O_SYS_RESET && !O_RESET_PIN_OE && !I_RESET_PIN_N && $past(I_RESET_PIN_N) == 1'b0 |=> O_SYS_RESET;
	endproperty
	a_extend: assert property (p_extend) else $error("left reset early");
	property p_read; I_CAUSE_READ && !O_CPU_RESET |=> O_RESET_CAUSE[7:4] == 4'h0; endproperty
	a_read: assert property (p_read) else $error("read kept flags");
	property p_fetch; $rose(O_PMEM_RD) |-> O_PMEM_ADDR == 16'h0002 ##1 O_PMEM_ADDR == 16'h0003; endproperty
	a_fetch: assert property (p_fetch) else $error("fetch order");
	property p_pc; $rose(O_PMEM_RD) |-> ##[1:4] O_PC_LOAD; endproperty
	a_pc: assert property (p_pc) else $error("no pc load");
	property p_dbg_clr; O_DBG_REQ_CLEAR |-> O_CPU_RESET ##1 !O_DBG_REQ_CLEAR; endproperty
	a_dbg_clr: assert property (p_dbg_clr) else $error("request clear");
	// clock switch only on a wake, never a full reset
	property p_ipo; O_OSC_IPO_SELECT |-> !O_SYS_RESET && O_PORT_IN_HOLD; endproperty
	a_ipo: assert property (p_ipo) else $error("osc select");
	property p_irq; O_WDT_IRQ |-> !I_WDT_RESET_MODE && I_IRQ_ENABLE; endproperty
	a_irq: assert property (p_irq) else $error("stray irq");
	c_pc: cover property ($rose(O_PC_LOAD));
	c_irq: cover property (O_WDT_IRQ);
	c_ipo: cover property (O_OSC_IPO_SELECT);
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// wires named as the ports so the instance connects by name
	logic I_CLK, I_ARST_N, I_RESET_PIN_N, O_RESET_PIN_N, O_RESET_PIN_OE, I_GPIO_RESET_DRIVE, I_OSC_TICK;
	logic I_XTAL_EN, I_STOP_MODE, I_WDT_TIMEOUT, I_WDT_RESET_MODE, I_IRQ_ENABLE, I_DBG_RESET_REQ;
	logic I_DBG_PIN, I_DBG_BIT_TICK, I_DBG_STOP_SAMPLE, I_DBG_TX_COLLISION, I_CAUSE_READ, O_SYS_RESET;
	logic O_CPU_RESET, O_DBG_REQ_CLEAR, O_DBG_ERROR, O_OSC_IPO_SELECT, O_WDT_IRQ, O_PORT_IN_HOLD;
	logic O_PORT_IN_LOAD, O_PMEM_RD, O_PC_LOAD;
	logic [7:0] I_GPIO_PINS, I_GPIO_WAKE_EN, I_PMEM_DATA, O_PORT_IN_DATA, O_RESET_CAUSE;
	logic [15:0] O_PMEM_ADDR, O_PC;
	logic pull_low; // source asserts the pin
	logic irq_seen; // interrupt pulse caught
	int n_fail = 0;
	int tests_run = 0;
	reset_and_stop_recovery_ctrl #(.P_HOLD_LONG(13'h0014)) DUT (.*);
	board_model u_board (.i_clk(I_CLK), .i_pull_low(pull_low), .i_oe(O_RESET_PIN_OE), .i_addr(O_PMEM_ADDR),
		.o_pin_n(I_RESET_PIN_N), .o_data(I_PMEM_DATA));
	// clock
	initial begin
		I_CLK = 1'b0;
		forever #5 I_CLK = ~I_CLK;
	end
	// oscillator tick every second cycle, so holds are twice the tick count
	always @(negedge I_CLK) I_OSC_TICK <= !I_OSC_TICK;
	always @(posedge I_CLK) if (O_WDT_IRQ === 1'b1) irq_seen <= 1'b1;
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_sim();
		if (n_fail == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// wait for vector load; n counts cycles
	task automatic wait_pc(output int n);
		n = 0;
		while (O_PC_LOAD !== 1'b1 && n < 20000) begin
			@(negedge I_CLK);
			n++;
		end
		if (n >= 20000) begin
			n_fail++;
		end
		chk("pc", O_PC, 16'hA53C);
		repeat (2) @(negedge I_CLK);
	endtask
	// hold stop until the wake is under way
	task automatic wake_wait();
		int n;
		n = 0;
		while (O_CPU_RESET !== 1'b1 && n < 20) begin
			@(negedge I_CLK);
			n++;
		end
		I_STOP_MODE = 1'b0;
	endtask
	task automatic t_pin();
		int n;
		wait_pc(n);
		chk("por_len", 16'(n >= 132 && n < 150), 16'h0001);
		pull_low = 1'b1;
		repeat (2) @(negedge I_CLK);
		pull_low = 1'b0;
		repeat (8) @(negedge I_CLK);
		chk("glitch", {15'h0000, O_SYS_RESET}, 16'h0000);
		pull_low = 1'b1;
		repeat (4) @(negedge I_CLK);
		pull_low = 1'b0;
		wait_pc(n);
		chk("ext_cause", {8'h00, O_RESET_CAUSE}, 16'h0010);
		pull_low = 1'b1;
		repeat (300) @(negedge I_CLK);
		chk("extend", {15'h0000, O_SYS_RESET}, 16'h0001);
		pull_low = 1'b0;
		wait_pc(n);
		chk("release", 16'(n < 12), 16'h0001);
	endtask
	task automatic t_read();
		I_CAUSE_READ = 1'b1;
		I_GPIO_RESET_DRIVE = 1'b1;
		@(negedge I_CLK);
		chk("oe_gpio", {15'h0000, O_RESET_PIN_OE}, 16'h0001);
		I_CAUSE_READ = 1'b0;
		I_GPIO_RESET_DRIVE = 1'b0;
		@(negedge I_CLK);
		chk("read_clr", {8'h00, O_RESET_CAUSE}, 16'h0000);
	endtask
	task automatic t_dbg();
		int n;
		I_DBG_RESET_REQ = 1'b1;
		n = 0;
		while (O_DBG_REQ_CLEAR !== 1'b1 && n < 50) begin
			@(negedge I_CLK);
			n++;
		end
		I_DBG_RESET_REQ = 1'b0;
		chk("dbg_clr", {15'h0000, O_DBG_REQ_CLEAR}, 16'h0001);
		wait_pc(n);
		chk("dbg_cause", {8'h00, O_RESET_CAUSE}, 16'h0080);
	endtask
	task automatic t_stop_wdt();
		int n;
		I_WDT_RESET_MODE = 1'b0;
		irq_seen = 1'b0;
		I_STOP_MODE = 1'b1;
		repeat (4) @(negedge I_CLK);
		I_WDT_TIMEOUT = 1'b1;
		@(negedge I_CLK);
		I_WDT_TIMEOUT = 1'b0;
		wake_wait();
		chk("wake_sys", {15'h0000, O_SYS_RESET}, 16'h0000);
		wait_pc(n);
		chk("wdt_cause", {8'h00, O_RESET_CAUSE}, 16'h0060);
		chk("wake_len", 16'(n >= 126 && n < 150), 16'h0001);
		chk("wdt_irq", {15'h0000, irq_seen}, 16'h0001);
		I_WDT_RESET_MODE = 1'b1;
	endtask
	task automatic t_stop_gpio();
		int n;
		I_XTAL_EN = 1'b1;
		I_GPIO_WAKE_EN = 8'h08;
		I_STOP_MODE = 1'b1;
		repeat (4) @(negedge I_CLK);
		I_GPIO_PINS = 8'h08;
		wake_wait();
		wait_pc(n);
		chk("gpio_cause", {8'h00, O_RESET_CAUSE}, 16'h0040);
		chk("xtal_len", 16'(n >= 34 && n < 56), 16'h0001);
		chk("port_data", {8'h00, O_PORT_IN_DATA}, 16'h0008);
		I_XTAL_EN = 1'b0;
	endtask
	task automatic t_stop_dbg();
		int n;
		I_STOP_MODE = 1'b1;
		repeat (4) @(negedge I_CLK);
		I_DBG_TX_COLLISION = 1'b1;
		@(negedge I_CLK);
		chk("dbg_err", {15'h0000, O_DBG_ERROR}, 16'h0001);
		I_DBG_TX_COLLISION = 1'b0;
		wake_wait();
		repeat (2) @(negedge I_CLK);
		chk("dbg_oe", {15'h0000, O_RESET_PIN_OE}, 16'h0001);
		wait_pc(n);
		chk("dbg_por", {8'h00, O_RESET_CAUSE}, 16'h0080);
	endtask
	initial begin
		I_ARST_N = 1'b0;
		pull_low = 1'b0;
		irq_seen = 1'b0;
		I_OSC_TICK = 1'b0;
		I_GPIO_RESET_DRIVE = 1'b0;
		I_XTAL_EN = 1'b0;
		I_STOP_MODE = 1'b0;
		I_WDT_TIMEOUT = 1'b0;
		I_WDT_RESET_MODE = 1'b1;
		I_IRQ_ENABLE = 1'b1;
		I_GPIO_PINS = 8'h00;
		I_GPIO_WAKE_EN = 8'h00;
		I_DBG_RESET_REQ = 1'b0;
		I_DBG_PIN = 1'b1;
		I_DBG_BIT_TICK = 1'b0;
		I_DBG_STOP_SAMPLE = 1'b0;
		I_DBG_TX_COLLISION = 1'b0;
		I_CAUSE_READ = 1'b0;
		repeat (5) @(negedge I_CLK);
		I_ARST_N = 1'b1;
		t_pin();
		t_read();
		t_dbg();
		t_stop_wdt();
		t_stop_gpio();
		t_stop_dbg();
		end_sim();
	end
	// hang guard, well beyond the roughly one thousand cycles expected
	initial begin
		#200us;
		n_fail++;
		end_sim();
	end
endmodule
bind reset_and_stop_recovery_ctrl rst_stop_monitor #(.P_HOLD_LONG(P_HOLD_LONG)) u_mon (.*);
`default_nettype wire
